// [logic/ssw_pkg.sv]
// Shared constants and types for the supply supervisor and watchdog
package ssw_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NUM_SUPPLIES = 8;
  localparam int SEL_W        = 5;
  localparam int TOL_BIT      = 4;
  localparam int CNT_W        = 32;
  localparam int PRE_W        = 8;
  localparam int SYNC_W       = 6 + SEL_W + NUM_SUPPLIES;

  // ----------------------------------------------------------------
  // Positions in the synchronised pin vector
  // ----------------------------------------------------------------
  localparam int POS_UV      = 0;
  localparam int POS_SEL     = NUM_SUPPLIES;
  localparam int POS_RST_ADJ = POS_SEL + SEL_W;
  localparam int POS_WD_ADJ  = POS_RST_ADJ + 1;
  localparam int POS_HOLD_N  = POS_RST_ADJ + 2;
  localparam int POS_ENA_N   = POS_RST_ADJ + 3;
  localparam int POS_MR_N    = POS_RST_ADJ + 4;
  localparam int POS_STROBE  = POS_RST_ADJ + 5;

  // ----------------------------------------------------------------
  // Time base and periods
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS       = 1000;
  localparam logic [PRE_W-1:0] TICK_CYCLES = PRE_W'((TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int PG_DELAY_US   = 6250;
  localparam int WD_SHORT_MS   = 1440;
  localparam int WD_LONG_MS    = 92160;
  localparam int RST_DEF_MS    = 140;
  localparam int WD_LONG_MULT  = 64;
  localparam int WD_ADJ_MS     = 100;
  localparam int RST_ADJ_MS    = 20;
  localparam int PG_DELAY_TICKS  = (PG_DELAY_US * 1000 + TICK_NS - 1) / TICK_NS;
  localparam int WD_SHORT_TICKS  = (WD_SHORT_MS * 1000) / TICK_NS * 1000;
  localparam int WD_LONG_TICKS   = (WD_LONG_MS * 1000) / TICK_NS * 1000;
  localparam int RST_DEF_TICKS   = (RST_DEF_MS * 1000) / TICK_NS * 1000;
  localparam int WD_ADJ_TICKS    = (WD_ADJ_MS * 1000) / TICK_NS * 1000;
  localparam int RST_ADJ_TICKS   = (RST_ADJ_MS * 1000) / TICK_NS * 1000;
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_RESET = 32'h0;
  localparam logic [PRE_W-1:0] PRE_RESET = 8'h0;
  localparam logic             RST_N_RESET   = 1'b0;
  localparam logic             FAULT_N_RESET = 1'b1;
  localparam logic             PG_N_RESET    = 1'b0;
  localparam logic [SEL_W-1:0] SEL_RESET     = 5'h00;

  typedef enum logic [2:0] {
    WD_LONG  = 3'b001,
    WD_SHORT = 3'b010,
    WD_FAULT = 3'b100
  } ssw_wd_state_t;

endpackage

// [logic/ssw_chan_if.sv]
// Signals between the supervisor top and one power-good channel
`timescale 1ns/1ns
interface ssw_chan_if;
  logic tick;
  logic undervolt;
  logic force_low;
  logic hold;
  logic pg_n;
  modport chan (input tick, input undervolt, input force_low, input hold, output pg_n);
  modport top  (output tick, output undervolt, output force_low, output hold, input pg_n);
endinterface // ssw_chan_if

// [logic/ssw_pg_chan.sv]
// One power-good channel with release delay
`timescale 1ns/1ns
module ssw_pg_chan #(
  parameter logic [ssw_pkg::CNT_W-1:0] DELAY_TICKS = ssw_pkg::CNT_W'(ssw_pkg::PG_DELAY_TICKS)
) (
  input wire logic  clock_in, // 125 MHz clock
  input wire logic  rstn_in,  // Async reset, active low
  ssw_chan_if.chan  ch        // Channel signals
);
  logic [ssw_pkg::CNT_W-1:0] cnt_r;
  logic [ssw_pkg::CNT_W-1:0] cnt_nxt;
  logic                      pg_n_r;
  logic                      pg_n_nxt;

  always_comb begin
    cnt_nxt  = cnt_r;
    pg_n_nxt = pg_n_r;
    if (!ch.hold) begin
      if (ch.undervolt || ch.force_low) begin
        cnt_nxt  = ssw_pkg::CNT_RESET;
        pg_n_nxt = 1'b0;
      end else if (!pg_n_r && ch.tick) begin
        if (cnt_r >= DELAY_TICKS - 32'h1) begin
          pg_n_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r  <= ssw_pkg::CNT_RESET;
      pg_n_r <= ssw_pkg::PG_N_RESET;
    end else begin
      cnt_r  <= cnt_nxt;
      pg_n_r <= pg_n_nxt;
    end
  end

  assign ch.pg_n = pg_n_r;

  a_pg_cause_low: assert property (@(posedge clock_in) disable iff (!rstn_in)
    (ch.undervolt || ch.force_low) && !ch.hold |=> !ch.pg_n) else $error("power good not pulled low");
  a_pg_hold_freeze: assert property (@(posedge clock_in) disable iff (!rstn_in)
    ch.hold |=> $stable(ch.pg_n)) else $error("power good moved during hold");
  a_pg_release_delay: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(ch.pg_n) |-> $past(cnt_r) == DELAY_TICKS - 32'h1 && $past(ch.tick))
    else $error("power good released before its delay");

endmodule // ssw_pg_chan

// [logic/ssw_top.sv]
// Supply supervisor: watchdog, combined reset and power-good outputs
`timescale 1ns/1ns
module ssw_top #(
  parameter logic [31:0] WD_SHORT_TICKS     = 32'(ssw_pkg::WD_SHORT_TICKS), // Fixed short period
  parameter logic [31:0] WD_LONG_TICKS      = 32'(ssw_pkg::WD_LONG_TICKS),  // Fixed long period
  parameter logic [31:0] WD_ADJ_SHORT_TICKS = 32'(ssw_pkg::WD_ADJ_TICKS),   // Adjusted short period
  parameter logic [31:0] RST_DEF_TICKS      = 32'(ssw_pkg::RST_DEF_TICKS),  // Default reset period
  parameter logic [31:0] RST_ADJ_TICKS      = 32'(ssw_pkg::RST_ADJ_TICKS),  // Adjusted reset period
  parameter logic [31:0] PG_DELAY_TICKS     = 32'(ssw_pkg::PG_DELAY_TICKS)  // Power-good release delay
) (
  input  wire logic                              clock_in,                  // 125 MHz clock
  input  wire logic                              rstn_in,                   // Async reset, active low
  input  wire logic                              watchdog_strobe_in,        // Strobe from host
  input  wire logic                              manual_reset_n_in,         // Manual reset, active low
  input  wire logic                              power_good_enable_n_in,    // High forces power-good low
  input  wire logic                              output_hold_n_in,          // Low freezes reset, fault and power-good outputs
  input  wire logic                              watchdog_period_adjust_in, // 1 selects adjusted period
  input  wire logic                              reset_period_adjust_in,    // 1 selects adjusted period
  input  wire logic [ssw_pkg::SEL_W-1:0]         threshold_select_in,       // Threshold code pins
  input  wire logic [ssw_pkg::NUM_SUPPLIES-1:0]  undervolt_in,              // Comparator flags, 1 = low
  output logic [ssw_pkg::NUM_SUPPLIES-1:0]       power_good_n_out,          // Per supply, low = not good
  output logic                                   reset_n_out,               // Combined reset, active low
  output logic                                   watchdog_fault_n_out,      // Watchdog fault, active low
  output logic [ssw_pkg::SEL_W-1:0]              threshold_code_out,        // Latched threshold code
  output logic                                   tolerance_5pct_out         // 1 = 5 %, 0 = 10 %
);
  localparam logic [31:0] WD_ADJ_LONG_TICKS = 32'(WD_ADJ_SHORT_TICKS * ssw_pkg::WD_LONG_MULT);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [ssw_pkg::SYNC_W-1:0] pins;
  logic [ssw_pkg::SYNC_W-1:0] meta_r;
  logic [ssw_pkg::SYNC_W-1:0] sync_r;
  logic                       strobe_prev_r;

  assign pins = {watchdog_strobe_in, manual_reset_n_in, power_good_enable_n_in, output_hold_n_in,
                 watchdog_period_adjust_in, reset_period_adjust_in, threshold_select_in, undervolt_in};

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_r        <= '0;
      sync_r        <= '0;
      strobe_prev_r <= 1'b0;
    end else begin
      meta_r        <= pins;
      sync_r        <= meta_r;
      strobe_prev_r <= sync_r[ssw_pkg::POS_STROBE];
    end
  end

  logic hold;
  logic strobe_edge;
  logic any_uv;
  logic rst_cause;
  assign hold        = !sync_r[ssw_pkg::POS_HOLD_N];
  assign strobe_edge = sync_r[ssw_pkg::POS_STROBE] ^ strobe_prev_r;
  assign any_uv      = |sync_r[ssw_pkg::POS_UV +: ssw_pkg::NUM_SUPPLIES];
  assign rst_cause   = any_uv || !sync_r[ssw_pkg::POS_MR_N];

  // ----------------------------------------------------------------
  // Time base and threshold capture
  // ----------------------------------------------------------------
  logic [ssw_pkg::PRE_W-1:0] pre_r;
  logic [ssw_pkg::PRE_W-1:0] pre_nxt;
  logic                      tick_r;
  logic                      tick_nxt;
  logic [1:0]                settle_r;
  logic [1:0]                settle_nxt;
  logic [ssw_pkg::SEL_W-1:0] sel_r;
  logic [ssw_pkg::SEL_W-1:0] sel_nxt;

  always_comb begin
    pre_nxt    = pre_r + 8'h1;
    tick_nxt   = 1'b0;
    settle_nxt = settle_r;
    sel_nxt    = sel_r;
    if (pre_r >= ssw_pkg::TICK_CYCLES - 8'h1) begin
      pre_nxt  = ssw_pkg::PRE_RESET;
      tick_nxt = 1'b1;
    end
    if (settle_r != ssw_pkg::SETTLE_CYCLES) begin
      settle_nxt = settle_r + 2'h1;
      if (settle_nxt == ssw_pkg::SETTLE_CYCLES) begin
        sel_nxt = sync_r[ssw_pkg::POS_SEL +: ssw_pkg::SEL_W];
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pre_r    <= ssw_pkg::PRE_RESET;
      tick_r   <= 1'b0;
      settle_r <= 2'h0;
      sel_r    <= ssw_pkg::SEL_RESET;
    end else begin
      pre_r    <= pre_nxt;
      tick_r   <= tick_nxt;
      settle_r <= settle_nxt;
      sel_r    <= sel_nxt;
    end
  end

  assign threshold_code_out = sel_r;
  assign tolerance_5pct_out = sel_r[ssw_pkg::TOL_BIT];

  // ----------------------------------------------------------------
  // Combined reset
  // ----------------------------------------------------------------
  logic [31:0] rst_cnt_r;
  logic [31:0] rst_cnt_nxt;
  logic        rst_n_r;
  logic        rst_n_nxt;
  logic [31:0] rst_limit;

  assign rst_limit = sync_r[ssw_pkg::POS_RST_ADJ] ? RST_ADJ_TICKS : RST_DEF_TICKS;

  always_comb begin
    rst_cnt_nxt = rst_cnt_r;
    rst_n_nxt   = rst_n_r;
    if (!hold) begin
      if (rst_cause) begin
        rst_cnt_nxt = ssw_pkg::CNT_RESET;
        rst_n_nxt   = 1'b0;
      end else if (!rst_n_r && tick_r) begin
        if (rst_cnt_r >= rst_limit - 32'h1) begin
          rst_n_nxt = 1'b1;
        end else begin
          rst_cnt_nxt = rst_cnt_r + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_cnt_r <= ssw_pkg::CNT_RESET;
      rst_n_r   <= ssw_pkg::RST_N_RESET;
    end else begin
      rst_cnt_r <= rst_cnt_nxt;
      rst_n_r   <= rst_n_nxt;
    end
  end

  assign reset_n_out = rst_n_r;

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  ssw_pkg::ssw_wd_state_t wd_st_r;
  ssw_pkg::ssw_wd_state_t wd_st_nxt;
  logic [31:0]            wd_cnt_r;
  logic [31:0]            wd_cnt_nxt;
  logic                   fault_n_r;
  logic                   fault_n_nxt;
  logic [31:0]            wd_limit;

  always_comb begin
    if (sync_r[ssw_pkg::POS_WD_ADJ]) begin
      wd_limit = (wd_st_r == ssw_pkg::WD_LONG) ? WD_ADJ_LONG_TICKS : WD_ADJ_SHORT_TICKS;
    end else begin
      wd_limit = (wd_st_r == ssw_pkg::WD_LONG) ? WD_LONG_TICKS : WD_SHORT_TICKS;
    end
  end

  always_comb begin
    wd_st_nxt   = wd_st_r;
    wd_cnt_nxt  = wd_cnt_r;
    fault_n_nxt = fault_n_r;
    if (!hold) begin
      if (!rst_n_r) begin
        wd_st_nxt   = ssw_pkg::WD_LONG;
        wd_cnt_nxt  = ssw_pkg::CNT_RESET;
        fault_n_nxt = 1'b1;
      end else if (strobe_edge) begin
        wd_st_nxt   = ssw_pkg::WD_SHORT;
        wd_cnt_nxt  = ssw_pkg::CNT_RESET;
        fault_n_nxt = 1'b1;
      end else begin
        unique case (wd_st_r)
          ssw_pkg::WD_LONG, ssw_pkg::WD_SHORT: begin
            if (tick_r) begin
              if (wd_cnt_r >= wd_limit - 32'h1) begin
                wd_st_nxt   = ssw_pkg::WD_FAULT;
                wd_cnt_nxt  = ssw_pkg::CNT_RESET;
                fault_n_nxt = 1'b0;
              end else begin
                wd_cnt_nxt = wd_cnt_r + 32'h1;
              end
            end
          end
          ssw_pkg::WD_FAULT: begin
            fault_n_nxt = 1'b0;
          end
          default: begin
            wd_st_nxt = ssw_pkg::WD_LONG;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wd_st_r   <= ssw_pkg::WD_LONG;
      wd_cnt_r  <= ssw_pkg::CNT_RESET;
      fault_n_r <= ssw_pkg::FAULT_N_RESET;
    end else begin
      wd_st_r   <= wd_st_nxt;
      wd_cnt_r  <= wd_cnt_nxt;
      fault_n_r <= fault_n_nxt;
    end
  end

  assign watchdog_fault_n_out = fault_n_r;

  // ----------------------------------------------------------------
  // Power-good channels
  // ----------------------------------------------------------------
  for (genvar i = 0; i < ssw_pkg::NUM_SUPPLIES; i++) begin : g_chan
    ssw_chan_if u_if ();
    assign u_if.tick      = tick_r;
    assign u_if.undervolt = sync_r[ssw_pkg::POS_UV + i];
    assign u_if.force_low = sync_r[ssw_pkg::POS_ENA_N];
    assign u_if.hold      = hold;
    assign power_good_n_out[i] = u_if.pg_n;
    ssw_pg_chan #(.DELAY_TICKS(PG_DELAY_TICKS)) u_chan (
      .clock_in (clock_in),
      .rstn_in  (rstn_in),
      .ch       (u_if.chan)
    );
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_rst_cause_low: assert property (@(posedge clock_in) disable iff (!rstn_in)
    rst_cause && !hold |=> !reset_n_out) else $error("reset not asserted for its cause");
  a_rst_release_period: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $rose(reset_n_out) |-> $past(rst_cnt_r) == $past(rst_limit) - 32'h1 && $past(tick_r))
    else $error("reset released early");
  a_hold_freeze_out: assert property (@(posedge clock_in) disable iff (!rstn_in)
    hold |=> $stable(reset_n_out) && $stable(watchdog_fault_n_out)) else $error("outputs moved in hold");
  a_wd_reset_long: assert property (@(posedge clock_in) disable iff (!rstn_in)
    !reset_n_out && !hold |=> wd_st_r == ssw_pkg::WD_LONG && wd_cnt_r == 32'h0)
    else $error("watchdog not long after reset");
  a_wd_edge_short: assert property (@(posedge clock_in) disable iff (!rstn_in)
    strobe_edge && reset_n_out && !hold |=> wd_st_r == ssw_pkg::WD_SHORT && wd_cnt_r == 32'h0)
    else $error("strobe edge did not restart short period");
  a_wd_fault_timeout: assert property (@(posedge clock_in) disable iff (!rstn_in)
    $fell(watchdog_fault_n_out) |-> $past(wd_cnt_r) == $past(wd_limit) - 32'h1 && $past(tick_r))
    else $error("watchdog fault at wrong count");
  a_sel_latched: assert property (@(posedge clock_in) disable iff (!rstn_in)
    settle_r == ssw_pkg::SETTLE_CYCLES |=> $stable(threshold_code_out)) else $error("threshold code moved");

endmodule // ssw_top

// [sim/ssw_host_model.sv]
// Host processor and regulator model driving the supervisor pins
`timescale 1ns/1ns
module ssw_host_model (
  input  wire logic                              clock_in,        // Bench clock
  input  wire logic [31:0]                       kick_every_in,   // Cycles between strobe edges, 0 = silent
  input  wire logic                              kick_now_in,     // One strobe edge at the next clock
  input  wire logic [ssw_pkg::NUM_SUPPLIES-1:0]  uv_req_in,       // Supplies the regulators pull low
  output logic                                   strobe_out,      // Watchdog strobe pin
  output logic [ssw_pkg::NUM_SUPPLIES-1:0]       undervolt_out    // Comparator flags, 1 = low
);
  logic [31:0]                      gap_r    = 32'h0;
  logic                             strobe_r = 1'b0;
  logic [ssw_pkg::NUM_SUPPLIES-1:0] uv_r     = '0;

  initial strobe_out = 1'b0;
  initial undervolt_out = '0;

  // ----------------------------------------------------------------
  // Strobe and supply flags
  // ----------------------------------------------------------------
  // Requests taken on the rising edge so a one-cycle request is never missed
  always @(posedge clock_in) begin
    uv_r  <= uv_req_in;
    gap_r <= gap_r + 32'h1;
    if (kick_now_in || (kick_every_in != 32'h0 && gap_r >= kick_every_in - 32'h1)) begin
      strobe_r <= ~strobe_r;
      gap_r    <= 32'h0;
    end
  end

  // Pins move on the falling edge, away from the design's sampling edge
  always @(negedge clock_in) begin
    strobe_out    <= strobe_r;
    undervolt_out <= uv_r;
  end
endmodule // ssw_host_model

// [sim/ssw_top_bench.sv]
// Self-checking bench for the supply supervisor top
`timescale 1ns/1ns
module ssw_top_bench;
  // ----------------------------------------------------------------
  // Shortened periods, in ticks of 125 clocks
  // ----------------------------------------------------------------
  localparam int T       = 125;
  localparam int WD_S    = 4;
  localparam int WD_L    = 8;
  localparam int WD_A    = 2;
  localparam int RST_D   = 5;
  localparam int RST_A   = 3;
  localparam int PG_D    = 3;
  localparam int CEILING = 60000;

  logic        clock_in  = 1'b0;
  logic        rstn_in   = 1'b0;
  logic        mr_n      = 1'b1;
  logic        en_n      = 1'b0;
  logic        hold_n    = 1'b1;
  logic        wd_adj    = 1'b0;
  logic        rst_adj   = 1'b0;
  logic [4:0]  sel       = 5'h12;
  logic [31:0] every     = 32'h0;
  logic        kick      = 1'b0;
  logic [7:0]  uv_req    = 8'h00;
  logic        strobe;
  logic [7:0]  uv;
  logic [7:0]  pg_n;
  logic        reset_n;
  logic        fault_n;
  logic [4:0]  code;
  logic        tol;
  logic        held;
  int          err_count = 0;
  int          compares  = 0;
  int          cycles    = 0;
  int          idx       = 0;
  int          n1;
  int          n2;

  always #4 clock_in = ~clock_in;

  ssw_host_model u_ssw_host_model (.clock_in(clock_in), .kick_every_in(every), .kick_now_in(kick),
    .uv_req_in(uv_req), .strobe_out(strobe), .undervolt_out(uv));

  ssw_top #(.WD_SHORT_TICKS(32'(WD_S)), .WD_LONG_TICKS(32'(WD_L)), .WD_ADJ_SHORT_TICKS(32'(WD_A)),
    .RST_DEF_TICKS(32'(RST_D)), .RST_ADJ_TICKS(32'(RST_A)), .PG_DELAY_TICKS(32'(PG_D))) u_ssw_top (
    .clock_in(clock_in), .rstn_in(rstn_in), .watchdog_strobe_in(strobe), .manual_reset_n_in(mr_n),
    .power_good_enable_n_in(en_n), .output_hold_n_in(hold_n), .watchdog_period_adjust_in(wd_adj),
    .reset_period_adjust_in(rst_adj), .threshold_select_in(sel), .undervolt_in(uv),
    .power_good_n_out(pg_n), .reset_n_out(reset_n), .watchdog_fault_n_out(fault_n),
    .threshold_code_out(code), .tolerance_5pct_out(tol));

  // ----------------------------------------------------------------
  // Checking and waiting helpers
  // ----------------------------------------------------------------
  task automatic final_report();
    if (err_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Tick phase is unknown to the bench, so one tick either way is allowed
  task automatic span(input int n, input int ticks);
    check(32'(n >= (ticks - 1) * T && n <= (ticks + 1) * T + 10), 32'h1);
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clock_in);
  endtask

  function automatic logic sig(input int which);
    case (which)
      0: return reset_n;
      1: return fault_n;
      2: return pg_n[idx];
      default: return &pg_n;
    endcase
  endfunction

  task automatic wait_for(input int which, input logic v, input int maxc, output int n);
    n = 0;
    while (sig(which) !== v && n < maxc) begin
      @(negedge clock_in);
      n++;
    end
  endtask

  task automatic pulse_kick();
    kick = 1'b1;
    cyc(1);
    kick = 1'b0;
  endtask

  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (cycles == CEILING) begin
      err_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(10);
    check(32'(reset_n), 32'h0);
    check(32'(fault_n), 32'h1);
    check(32'(code), 32'h0);
    rstn_in = 1'b1;
    wait_for(0, 1'b1, 20 * T, n1);
    span(n1, RST_D);
    check(32'(pg_n), 32'hff);
    check(32'(code), 32'h12);
    check(32'(tol), 32'h1);
    sel = 5'h0c;
    cyc(6);
    check(32'(code), 32'h12);
    check(32'(tol), 32'h1);
    // Watchdog: long period from reset, short after first edge
    wait_for(1, 1'b0, 20 * T, n1);
    span(n1, WD_L);
    pulse_kick();
    wait_for(1, 1'b1, 20, n1);
    check(32'(fault_n), 32'h1);
    wait_for(1, 1'b0, 20 * T, n2);
    span(n1 + n2 + 1, WD_S);
    every = 32'(2 * T);
    wait_for(1, 1'b1, 3 * T, n1);
    wait_for(1, 1'b0, 20 * T, n1);
    check(32'(n1), 32'(20 * T));
    every = 32'h0;
    // Manual reset with the adjusted reset period
    mr_n = 1'b0;
    rst_adj = 1'b1;
    wait_for(0, 1'b0, 8, n1);
    check(32'(reset_n), 32'h0);
    cyc(50);
    check(32'(fault_n), 32'h1);
    mr_n = 1'b1;
    wait_for(0, 1'b1, 20 * T, n1);
    span(n1, RST_A);
    wait_for(1, 1'b0, 20 * T, n1);
    span(n1, WD_L);
    // Adjusted watchdog: long is 64 adjusted short periods
    wd_adj = 1'b1;
    rst_adj = 1'b0;
    mr_n = 1'b0;
    cyc(20);
    mr_n = 1'b1;
    wait_for(0, 1'b1, 20 * T, n1);
    span(n1, RST_D);
    wait_for(1, 1'b0, 140 * T, n1);
    span(n1, 64 * WD_A);
    pulse_kick();
    wait_for(1, 1'b1, 20, n1);
    wait_for(1, 1'b0, 20 * T, n2);
    span(n1 + n2 + 1, WD_A);
    // Each supply alone drops its power-good and the reset
    for (idx = 0; idx < 8; idx++) begin
      uv_req = 8'h01 << idx;
      wait_for(0, 1'b0, 10, n1);
      check(32'(reset_n), 32'h0);
      check(32'(pg_n), {24'h0, ~uv_req});
      uv_req = 8'h00;
      wait_for(2, 1'b1, 20 * T, n1);
      span(n1, PG_D);
      wait_for(0, 1'b1, 20 * T, n2);
      span(n1 + n2, RST_D);
    end
    en_n = 1'b1;
    cyc(6);
    check(32'(pg_n), 32'h00);
    en_n = 1'b0;
    wait_for(3, 1'b1, 20 * T, n1);
    span(n1, PG_D);
    // Hold freezes outputs and beats manual reset
    hold_n = 1'b0;
    cyc(4);
    held = fault_n;
    mr_n = 1'b0;
    uv_req = 8'hff;
    cyc(10 * T);
    check(32'(reset_n), 32'h1);
    check(32'(pg_n), 32'hff);
    check(32'(fault_n), 32'(held));
    hold_n = 1'b1;
    wait_for(0, 1'b0, 10, n1);
    check(32'(reset_n), 32'h0);
    final_report();
  end
endmodule // ssw_top_bench
